// ### hw/tfel_pkg.sv
// Package of shared types and constants for the timer flag and event logic.
package tfel_pkg;

    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONES = 16'hFFFF;
    localparam logic [15:0] MOD_NONE = 16'h0000;

    // Channel operating modes.
    typedef enum logic [1:0] {
        TFEL_CH_CAPTURE = 2'b00,
        TFEL_CH_COMPARE = 2'b01,
        TFEL_CH_PWM = 2'b10
    } tfel_ch_mode_e;

    // Edge choice for input capture.
    typedef enum logic [1:0] {
        TFEL_EDGE_OFF = 2'b00,
        TFEL_EDGE_RISE = 2'b01,
        TFEL_EDGE_FALL = 2'b10,
        TFEL_EDGE_ANY = 2'b11
    } tfel_edge_e;

    // Software flag access, one-cycle strobes from the register logic.
    typedef struct packed {
        logic rd;
        logic wr_zero;
    } tfel_flag_acc_s;

endpackage : tfel_pkg

// ### hw/tfel_flag_cell.sv
// One sticky event flag with read-then-write-zero clearing and interrupt gating.
`timescale 1ns/1ps
module tfel_flag_cell
    import tfel_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic set_evt,
    input wire tfel_flag_acc_s acc,
    input wire logic irq_enable,
    output logic flag,
    output logic irq
);

    logic armed;
    logic clear_now;

    // The clear only counts when armed and no event is arriving in that cycle.
    assign clear_now = armed && acc.wr_zero && !set_evt;

    // The flag; a set always beats a clear.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (set_evt) begin
            flag <= 1'b1;
        end else if (clear_now) begin
            flag <= 1'b0;
        end
    end

    // Arming: a read while set arms, a new event or any write disarms.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (set_evt || acc.wr_zero) begin
            armed <= 1'b0;
        end else if (acc.rd && flag) begin
            armed <= 1'b1;
        end
    end

    // Level request while enabled and set.
    assign irq = flag && irq_enable;

    flag_stays_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag && !armed && !set_evt) |=> flag)
        else $error("Flag cleared without a prior read.");

    clear_done_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (armed && acc.wr_zero && !set_evt) |=> !flag)
        else $error("Armed zero write did not clear the flag.");

    set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        set_evt |=> (flag && !armed))
        else $error("New event did not keep the flag set and disarmed.");

    irq_level_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (irq && !clear_now) |=> (irq || !irq_enable))
        else $error("Interrupt request dropped while the flag stayed set.");

endmodule : tfel_flag_cell

// ### hw/tfel_core.sv
// Counter and flag-setting logic of a 16-bit timer with capture, compare and PWM channels.
// Summary of operation
// - Free count wraps all-ones to zero.
// - Free count wrap sets the wrap flag.
// - Modulus to zero sets the wrap flag.
// - Up/down turnaround at modulus sets wrap flag.
// - Turnaround ends period, zero marks center.
// - Two-bit edge select picks capture edge.
// - Selected capture edge sets channel flag.
// - Compare match sets channel flag.
// - Edge PWM match ends duty, sets flag.
// - Center PWM sets flag on both matches.
// - Read while set, then write zero clears.
// - Event between steps keeps flag set.
// - Enabled flag holds a level request.
// - Center select picks up or up/down.
`timescale 1ns/1ps
module tfel_core
    import tfel_pkg::*;
#(
    parameter int NUM_CH = 6
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic count_en,
    input wire logic center_align_select,
    input wire logic [15:0] modulus,
    input wire logic wrap_irq_enable,
    input wire tfel_flag_acc_s wrap_acc,
    input wire logic [NUM_CH-1:0] channel_irq_enable,
    input wire tfel_ch_mode_e [NUM_CH-1:0] ch_mode,
    input wire tfel_edge_e [NUM_CH-1:0] edge_level_select,
    input wire logic [NUM_CH-1:0][15:0] ch_value,
    input wire logic [NUM_CH-1:0] ch_pin,
    input wire tfel_flag_acc_s [NUM_CH-1:0] ch_acc,
    output logic [15:0] count,
    output logic count_down,
    output logic counter_wrap_flag,
    output logic wrap_irq,
    output logic period_center,
    output logic [NUM_CH-1:0] channel_event_flag,
    output logic [NUM_CH-1:0] channel_irq
);

    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
        $error("NUM_CH must lie between 1 and 8.");
    end

    // Reset release through two flip-flops, so that every flop leaves reset on one edge.
    // Assertion of reset takes effect at once; only the release waits for the clock.
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Terminal count: modulus zero means free running to all-ones.
    logic mod_limited;
    logic [15:0] top;
    logic at_top;
    logic at_zero;
    logic wrap_up;
    logic turn_down;
    logic [15:0] next_count;
    logic next_down;
    assign mod_limited = (modulus != MOD_NONE);
    assign top = mod_limited ? modulus : CNT_ONES;
    assign at_top = (count == top);
    assign at_zero = (count == CNT_ZERO);
    // Up-counting wrap event, both free and limited.
    assign wrap_up = count_en && !center_align_select && at_top;
    // Up/down turnaround event from the modulus value downward.
    assign turn_down = count_en && center_align_select && !count_down && at_top;

    // Next counter value; modulus zero in up/down mode takes all-ones as its top and turns around there.
    // Counting down ends at zero, where the count turns upward again with no flag.
    always_comb begin
        next_count = count;
        next_down = count_down;
        if (!center_align_select) begin
            next_down = 1'b0;
            next_count = at_top ? CNT_ZERO : count + 16'h0001;
        end else if (count_down) begin
            if (at_zero) begin
                next_down = 1'b0;
                next_count = count + 16'h0001;
            end else begin
                next_count = count - 16'h0001;
            end
        end else if (at_top) begin
            next_down = 1'b1;
            next_count = count - 16'h0001;
        end else begin
            next_count = count + 16'h0001;
        end
    end

    // Counter register, advanced only on counting clock enables.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= CNT_ZERO;
            count_down <= 1'b0;
        end else if (count_en) begin
            count <= next_count;
            count_down <= next_down;
        end
    end

    // Zero count in up/down mode marks the period center; the turnaround marks the end.
    // It is a plain decode, so it stands for as long as the count stays at zero.
    assign period_center = center_align_select && at_zero;

    // Wrap flag cell, set on the same edge as the transition.
    tfel_flag_cell u_wrap_flag (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .set_evt(wrap_up || turn_down),
        .acc(wrap_acc),
        .irq_enable(wrap_irq_enable),
        .flag(counter_wrap_flag),
        .irq(wrap_irq)
    );

    // Pin synchronisers: three stages, the change counts once the last two agree.
    // This costs about five clocks of capture latency but filters a one-clock glitch.
    logic [NUM_CH-1:0] pin_s1;
    logic [NUM_CH-1:0] pin_s2;
    logic [NUM_CH-1:0] pin_s3;
    logic [NUM_CH-1:0] pin_level;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_level <= '0;
        end else begin
            pin_s1 <= ch_pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_level <= ((pin_s2 ~^ pin_s3) & pin_s3) | (~(pin_s2 ~^ pin_s3) & pin_level);
        end
    end
    // The level register starts low, so a pin held high at reset shows one rising edge.
    logic [NUM_CH-1:0] pin_prev;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_level;
        end
    end

    // Edge choice decoder.
    function automatic logic edge_hit(input tfel_edge_e sel, input logic now, input logic was);
        logic rise;
        logic fall;
        rise = now && !was;
        fall = !now && was;
        unique case (sel)
            TFEL_EDGE_OFF: edge_hit = 1'b0;
            TFEL_EDGE_RISE: edge_hit = rise;
            TFEL_EDGE_FALL: edge_hit = fall;
            TFEL_EDGE_ANY: edge_hit = rise || fall;
        endcase
    endfunction : edge_hit

    // Compare and both PWM kinds share the match event; the unused code raises nothing.
    function automatic logic match_mode(input tfel_ch_mode_e mode);
        return (mode == TFEL_CH_COMPARE) || (mode == TFEL_CH_PWM);
    endfunction : match_mode

    // Per-channel events and flag cells.
    logic [NUM_CH-1:0] ch_match;
    logic [NUM_CH-1:0] ch_cap;
    logic [NUM_CH-1:0] ch_set;
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        // Compare match on a counting step; in center mode the counter passes a value between zero and the top
        // once going up and once going down, so both matches raise the flag.
        assign ch_match[i] = count_en && (count == ch_value[i]);
        assign ch_cap[i] = edge_hit(edge_level_select[i], pin_level[i], pin_prev[i]);
        assign ch_set[i] = (ch_mode[i] == TFEL_CH_CAPTURE) ? ch_cap[i] :
                           (match_mode(ch_mode[i]) ? ch_match[i] : 1'b0);

        tfel_flag_cell u_ch_flag (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .set_evt(ch_set[i]),
            .acc(ch_acc[i]),
            .irq_enable(channel_irq_enable[i]),
            .flag(channel_event_flag[i]),
            .irq(channel_irq[i])
        );

        // Every selected capture edge reaches the flag on the next clock.
        capture_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            (ch_mode[i] == TFEL_CH_CAPTURE && ch_cap[i]) |=> channel_event_flag[i])
            else $error("Selected capture edge did not set the channel flag.");

        // An output compare match raises the flag on the counting step.
        compare_hit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            (ch_mode[i] == TFEL_CH_COMPARE && ch_match[i]) |=> channel_event_flag[i])
            else $error("Output compare match did not set the channel flag.");

        // In edge PWM the match ends the duty portion and raises the flag.
        edge_pwm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            (ch_mode[i] == TFEL_CH_PWM && !center_align_select && ch_match[i])
            |=> channel_event_flag[i])
            else $error("Edge PWM match did not set the channel flag.");

        // In center PWM the downward match counts as much as the upward one.
        center_pwm_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            (ch_mode[i] == TFEL_CH_PWM && center_align_select && count_down && ch_match[i])
            |=> channel_event_flag[i])
            else $error("Downward center PWM match did not set the channel flag.");

        // No flag may rise unless the decoder saw an event on the edge before.
        chan_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
            $rose(channel_event_flag[i]) |-> $past(ch_set[i]))
            else $error("Channel flag rose without an event.");
    end

    // Counter checks; the internal reset releases them all on the same edge.
    wrap_sets_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && !center_align_select && count == top) |=> counter_wrap_flag)
        else $error("Wrap did not set the wrap flag.");

    free_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && !center_align_select && !mod_limited && count == CNT_ONES)
        |=> count == CNT_ZERO)
        else $error("Free count did not wrap to zero.");

    // In up mode, below the top the count climbs by one on every enable.
    up_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && !center_align_select && count != top)
        |=> count == $past(count) + 16'h0001)
        else $error("Up count did not advance by one.");

    mod_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && !center_align_select && mod_limited && count == modulus)
        |=> count == CNT_ZERO)
        else $error("Modulus count did not return to zero.");

    turn_down_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && center_align_select && !count_down && count == top && count != CNT_ZERO)
        |=> count_down && counter_wrap_flag && count == $past(count) - 16'h0001)
        else $error("Turnaround did not count down and set the flag.");

    down_step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && center_align_select && count_down && count != CNT_ZERO)
        |=> (count_down && count == $past(count) - 16'h0001))
        else $error("Down count did not step down by one.");

    // At zero in up/down mode the count turns upward again.
    turn_up_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && center_align_select && count_down && count == CNT_ZERO)
        |=> (!count_down && count == CNT_ZERO + 16'h0001))
        else $error("Center count did not turn upward at zero.");

    center_mark_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (count_en && center_align_select && count_down && count == CNT_ZERO + 16'h0001)
        |=> (period_center || !center_align_select))
        else $error("Center mark missing at the zero count.");

    mode_up_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (!center_align_select && count_en) |=> !count_down)
        else $error("Up mode counted down.");

    // A flag that rises on its own would raise a request with no cause.
    wrap_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(counter_wrap_flag) |-> $past(wrap_up || turn_down))
        else $error("Wrap flag rose without a wrap or turnaround.");

    // Between counting enables the counter must hold, whatever the mode.
    count_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !count_en |=> (count == $past(count) && count_down == $past(count_down)))
        else $error("Counter moved without a counting enable.");

    // Channel zero stands for all channels in these two.
    match_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (match_mode(ch_mode[0]) && count_en && count == ch_value[0])
        |=> channel_event_flag[0])
        else $error("Compare match did not set the channel flag.");

    capture_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (ch_mode[0] == TFEL_CH_CAPTURE && edge_level_select[0] == TFEL_EDGE_OFF
         && !channel_event_flag[0]) |=> !channel_event_flag[0])
        else $error("Capture fired with edges off.");

    // Checked without the disable, since it guards the reset itself.
    reset_clear_a: assert property (@(posedge core_clk)
        !rst_n |-> (!counter_wrap_flag && !wrap_irq && channel_irq == '0))
        else $error("Flags or requests active in reset.");

endmodule : tfel_core

// ### test/tb_top.sv
// Self-checking testbench for the timer flag and event logic.
`timescale 1ns/1ps
module tb_top;
    import tfel_pkg::*;
    localparam int NC = 2;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic count_en = 1'b0;
    logic center_align_select = 1'b0;
    logic [15:0] modulus = 16'h0000;
    logic wrap_irq_enable = 1'b0;
    tfel_flag_acc_s wrap_acc = '0;
    logic [NC-1:0] channel_irq_enable = '0;
    tfel_ch_mode_e [NC-1:0] ch_mode;
    tfel_edge_e [NC-1:0] edge_level_select;
    logic [NC-1:0][15:0] ch_value;
    logic [NC-1:0] ch_pin = '0;
    tfel_flag_acc_s [NC-1:0] ch_acc;
    logic [15:0] count;
    logic count_down;
    logic counter_wrap_flag;
    logic wrap_irq;
    logic period_center;
    logic [NC-1:0] channel_event_flag;
    logic [NC-1:0] channel_irq;
    int error_cnt = 0;
    int num_checks = 0;
    logic [31:0] lfsr = 32'h86D6;
    logic chk_on = 1'b0;
    logic rnd_on = 1'b0;
    logic [NC-1:0] cmp_mask = '0;
    logic [15:0] m_cnt;
    logic m_dn;
    logic [NC:0] m_flag;
    logic [NC:0] m_arm;
    logic [NC:0] m_evt;

    tfel_core #(.NUM_CH(NC)) dut_u (.core_clk(core_clk), .rstn(rstn), .count_en(count_en),
        .center_align_select(center_align_select), .modulus(modulus),
        .wrap_irq_enable(wrap_irq_enable), .wrap_acc(wrap_acc),
        .channel_irq_enable(channel_irq_enable), .ch_mode(ch_mode),
        .edge_level_select(edge_level_select), .ch_value(ch_value), .ch_pin(ch_pin),
        .ch_acc(ch_acc), .count(count), .count_down(count_down),
        .counter_wrap_flag(counter_wrap_flag), .wrap_irq(wrap_irq),
        .period_center(period_center), .channel_event_flag(channel_event_flag),
        .channel_irq(channel_irq));

    // Clock at 40 MHz.
    always #12.5 core_clk = ~core_clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Rare read and clear strobes, never both at once, so clears meet fresh events.
    function automatic tfel_flag_acc_s acc_pick(input logic [2:0] v);
        tfel_flag_acc_s a;
        a.rd = (v == 3'h0);
        a.wr_zero = (v == 3'h1);
        return a;
    endfunction : acc_pick

    // Reference model of counter and flags, stepped on the same edges as the design.
    always @(posedge core_clk) begin : ref_model
        tfel_flag_acc_s a;
        logic [15:0] top;
        m_evt = '0;
        top = (modulus == 16'h0000) ? 16'hFFFF : modulus;
        if (!rstn) begin
            m_cnt = 16'h0000;
            m_dn = 1'b0;
            m_flag = '0;
            m_arm = '0;
        end else begin
            if (count_en) begin
                for (int i = 0; i < NC; i++)
                    m_evt[i] = (ch_mode[i] == TFEL_CH_COMPARE || ch_mode[i] == TFEL_CH_PWM)
                        && (m_cnt == ch_value[i]);
                if (!center_align_select || !m_dn) begin
                    m_evt[NC] = (m_cnt == top);
                    m_dn = center_align_select && m_evt[NC];
                    m_cnt = !m_evt[NC] ? m_cnt + 16'h0001 :
                        (center_align_select ? m_cnt - 16'h0001 : 16'h0000);
                end else begin
                    m_dn = (m_cnt != 16'h0000);
                    m_cnt = m_dn ? m_cnt - 16'h0001 : 16'h0001;
                end
            end
            for (int i = 0; i <= NC; i++) begin
                a = (i == NC) ? wrap_acc : ch_acc[i];
                if (m_evt[i]) begin
                    m_flag[i] = 1'b1;
                    m_arm[i] = 1'b0;
                end else if (a.rd && m_flag[i]) begin
                    m_arm[i] = 1'b1;
                end else if (a.wr_zero) begin
                    m_flag[i] = m_flag[i] && !m_arm[i];
                    m_arm[i] = 1'b0;
                end
            end
        end
    end

    task automatic chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    task automatic test_done();
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Compare against the model at each falling edge, then drive the next inputs.
    task automatic step(input int n);
        repeat (n) begin
            @(negedge core_clk);
            if (chk_on) begin
                chk16("count", m_cnt, count);
                chk1("count_down", m_dn, count_down);
                chk1("counter_wrap_flag", m_flag[NC], counter_wrap_flag);
                chk1("wrap_irq", m_flag[NC] & wrap_irq_enable, wrap_irq);
                chk1("period_center", center_align_select && m_cnt == 16'h0000, period_center);
                for (int i = 0; i < NC; i++) begin
                    if (cmp_mask[i]) begin
                        chk1("channel_event_flag", m_flag[i], channel_event_flag[i]);
                        chk1("channel_irq", m_flag[i] & channel_irq_enable[i], channel_irq[i]);
                    end
                end
            end
            if (rnd_on) begin
                lfsr = lfsr_next(lfsr);
                count_en = lfsr[0] | lfsr[1];
                wrap_acc = acc_pick(lfsr[4:2]);
                for (int i = 0; i < NC; i++)
                    ch_acc[i] = acc_pick(lfsr[3*i+7 -: 3]);
                wrap_irq_enable = lfsr[13];
                channel_irq_enable = lfsr[15:14];
            end
        end
    endtask : step

    // Reset in mid-run with flags likely set; enables and strobes are held low meanwhile.
    task automatic restart(input logic ctr, input logic [15:0] md);
        @(negedge core_clk);
        chk_on = 1'b0;
        rstn = 1'b0;
        count_en = 1'b0;
        wrap_acc = '0;
        ch_acc = '0;
        wrap_irq_enable = 1'b0;
        channel_irq_enable = '0;
        #1;
        chk16("count", 16'h0000, count);
        chk1("counter_wrap_flag", 1'b0, counter_wrap_flag);
        chk16("channel_event_flag", 16'h0000, {14'h0000, channel_event_flag});
        repeat (10) @(negedge core_clk);
        center_align_select = ctr;
        modulus = md;
        rstn = 1'b1;
        repeat (3) @(negedge core_clk);
        chk_on = 1'b1;
    endtask : restart

    // Read while set, then write zero, on channel zero.
    task automatic clear0();
        @(negedge core_clk);
        ch_acc[0].rd = 1'b1;
        @(negedge core_clk);
        ch_acc[0].rd = 1'b0;
        @(negedge core_clk);
        ch_acc[0].wr_zero = 1'b1;
        @(negedge core_clk);
        ch_acc[0].wr_zero = 1'b0;
        @(negedge core_clk);
        chk1("channel_event_flag", 1'b0, channel_event_flag[0]);
    endtask : clear0

    // Watchdog sized well above the full free-running wrap phase.
    initial begin
        repeat (90000) @(posedge core_clk);
        error_cnt++;
        test_done();
    end

    // Main sequence: up, up/down, capture edges, then a full free-running wrap.
    initial begin
        for (int i = 0; i < NC; i++) begin
            ch_mode[i] = lfsr[i] ? TFEL_CH_PWM : TFEL_CH_COMPARE;
            edge_level_select[i] = TFEL_EDGE_OFF;
            ch_value[i] = {13'h0000, lfsr[3*i+4 -: 3]};
            ch_acc[i] = '0;
        end
        cmp_mask = '1;
        restart(1'b0, 16'h0007);
        ch_value[1] = 16'h0007;
        rnd_on = 1'b1;
        step(400);
        ch_value[1] = 16'h0003;
        restart(1'b1, 16'h0005);
        rnd_on = 1'b1;
        step(400);
        rnd_on = 1'b0;
        ch_mode[0] = TFEL_CH_CAPTURE;
        // Channel one takes the unused mode code and must stay quiet while the count runs.
        ch_mode[1] = tfel_ch_mode_e'(2'b11);
        cmp_mask = 2'b10;
        restart(1'b0, 16'h0000);
        count_en = 1'b1;
        for (int k = 0; k < 4; k++) begin
            edge_level_select[0] = tfel_edge_e'(k);
            ch_pin[0] = 1'b1;
            step(8);
            chk1("channel_event_flag", k == 1 || k == 3, channel_event_flag[0]);
            clear0();
            ch_pin[0] = 1'b0;
            step(8);
            chk1("channel_event_flag", k >= 2, channel_event_flag[0]);
            clear0();
        end
        ch_mode[0] = TFEL_CH_COMPARE;
        ch_mode[1] = TFEL_CH_COMPARE;
        ch_value[0] = 16'hFFFF;
        ch_value[1] = 16'h0000;
        cmp_mask = '1;
        restart(1'b0, 16'h0000);
        count_en = 1'b1;
        step(65540);
        test_done();
    end
endmodule : tb_top
